// ### shared/bsfu_map.svh
// constants of the branch and skip flow unit: register offsets, fields, resets, cycle counts
// assumes a 32-bit apb slave with word-aligned registers and a 22-bit program counter
// Functional notes
// - pointer jump: pc low from pointer, 2 cycles
// - pointer call: same load, 3 or 4 cycles
// - compare-skip on equal: pc+2/3, flags untouched
// - skip when register bit is zero
// - skip when register bit is one
// - skip when io bit is zero
// - skip when io bit is one
// - branch when selected flag is one
// - branch when selected flag is zero
// - branch when carry flag is zero
// - unsigned same-or-higher means carry zero
// - signed ge when negative xor overflow zero
// - signed lt when negative xor overflow one
// - branch when half-carry is one
// - branch when half-carry is zero
// - branch when transfer bit is one
// - branch when transfer bit is zero
// - branch when overflow is one
// - branch when overflow is zero
// - branch when interrupt enable is one
// - branch when interrupt enable is zero
`ifndef BSFU_MAP_SVH
`define BSFU_MAP_SVH

`define BSFU_PC_W        22
`define BSFU_PTR_W       16
`define BSFU_K_W         7

`define BSFU_OFF_CTRL    12'h000
`define BSFU_OFF_STATUS  12'h004
`define BSFU_OFF_LAST_PC 12'h008
`define BSFU_OFF_REDIR   12'h00c

`define BSFU_CTRL_EN     0
`define BSFU_CTRL_WIDE   1
`define BSFU_CTRL_RST    2'h3

`define BSFU_FLG_C       0
`define BSFU_FLG_Z       1
`define BSFU_FLG_N       2
`define BSFU_FLG_V       3
`define BSFU_FLG_S       4
`define BSFU_FLG_H       5
`define BSFU_FLG_T       6
`define BSFU_FLG_I       7

`define BSFU_CYC_SEQ     3'h1
`define BSFU_CYC_JUMP    3'h2
`define BSFU_CYC_CALL16  3'h3
`define BSFU_CYC_CALL22  3'h4
`define BSFU_CYC_SKIP1   3'h2
`define BSFU_CYC_SKIP2   3'h3
`define BSFU_CYC_BRANCH  3'h2

`endif

// ### shared/bsfu_pkg.sv
// types of the branch and skip flow unit
// assumes bsfu_map.svh sits on the include path
`include "bsfu_map.svh"
package bsfu_pkg;

	typedef logic [`BSFU_PC_W-1:0] bsfu_pc_t;

	typedef enum logic [4:0] {
		BSFU_NOP              = 5'h00,
		BSFU_POINTER_JUMP     = 5'h01,
		BSFU_POINTER_CALL     = 5'h02,
		BSFU_COMPARE_SKIP_EQ  = 5'h03,
		BSFU_SKIP_REG_BIT_LOW = 5'h04,
		BSFU_SKIP_REG_BIT_HIGH= 5'h05,
		BSFU_SKIP_IO_BIT_LOW  = 5'h06,
		BSFU_SKIP_IO_BIT_HIGH = 5'h07,
		BSFU_BRANCH_FLAG_HIGH = 5'h08,
		BSFU_BRANCH_FLAG_LOW  = 5'h09,
		BSFU_BRANCH_NO_CARRY  = 5'h0a,
		BSFU_BRANCH_UNS_GE    = 5'h0b,
		BSFU_BRANCH_SIGNED_GE = 5'h0c,
		BSFU_BRANCH_SIGNED_LT = 5'h0d,
		BSFU_BRANCH_HC_ON     = 5'h0e,
		BSFU_BRANCH_HC_OFF    = 5'h0f,
		BSFU_BRANCH_XFER_ON   = 5'h10,
		BSFU_BRANCH_XFER_OFF  = 5'h11,
		BSFU_BRANCH_OVF_ON    = 5'h12,
		BSFU_BRANCH_OVF_OFF   = 5'h13,
		BSFU_BRANCH_IRQ_ON    = 5'h14,
		BSFU_BRANCH_IRQ_OFF   = 5'h15
	} bsfu_op_e;

	typedef enum logic [1:0] {
		BSFU_IDLE = 2'h0,
		BSFU_HOLD = 2'h1
	} bsfu_fsm_e;

	typedef struct packed {
		bsfu_op_e              op;
		bsfu_pc_t              pc;
		logic [`BSFU_PTR_W-1:0] zptr;
		logic [7:0]            rd_val;
		logic [7:0]            rr_val;
		logic [2:0]            bit_sel;
		logic                  io_bit;
		logic [7:0]            flags;
		logic [`BSFU_K_W-1:0]  offset;
		logic                  next_two_word;
	} bsfu_req_s;

	typedef struct packed {
		logic     done;
		logic     taken;
		bsfu_pc_t pc_next;
		logic [2:0] cycles;
	} bsfu_res_s;

	typedef struct packed {
		logic     valid;
		bsfu_pc_t addr;
	} bsfu_push_s;

	typedef struct packed {
		bsfu_fsm_e  fsm;
		logic [2:0] cnt;
		logic       hold_taken;
		bsfu_pc_t   hold_pc;
		logic [2:0] hold_cyc;
		bsfu_op_e   last_op;
		bsfu_res_s  res;
		bsfu_push_s push;
		logic       ctrl_en;
		logic       ctrl_wide;
		bsfu_pc_t   last_pc;
		logic [15:0] redir_cnt;
		logic [31:0] prdata;
		logic       pslverr;
	} bsfu_state_s;

endpackage

// ### hw/bsfu_flow_unit.sv
// branch and skip flow unit: next pc, taken flag and cycle count for control-flow instructions
// assumes decode presents one request at a time with operands already read; apb for control
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "bsfu_map.svh"
module bsfu_flow_unit
	import bsfu_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  bsfu_req_s        req,
	input  wire logic        req_valid,
	output logic             req_ready,
	output bsfu_res_s        res,
	output bsfu_push_s       push
);

	bsfu_state_s s_reg;
	bsfu_state_s s_next;
	logic        take;
	logic        cond;
	logic [2:0]  cyc;
	bsfu_pc_t    tgt;
	bsfu_pc_t    seq_pc;
	bsfu_pc_t    br_pc;
	logic        fin;
	logic        fin_taken;
	bsfu_pc_t    fin_pc;
	logic [2:0]  fin_cyc;
	logic [2:0]  rd_idx;
	logic [2:0]  wr_idx;

	// register index of an apb address, 3'h4 when unmapped
	function automatic logic [2:0] reg_index(input logic [11:0] a);
		if (a == `BSFU_OFF_CTRL) begin
			return 3'h0;
		end else if (a == `BSFU_OFF_STATUS) begin
			return 3'h1;
		end else if (a == `BSFU_OFF_LAST_PC) begin
			return 3'h2;
		end else if (a == `BSFU_OFF_REDIR) begin
			return 3'h3;
		end else begin
			return 3'h4;
		end
	endfunction

	// condition of the conditional branches on the status flags
	function automatic logic branch_cond(input bsfu_op_e op, input logic [7:0] f, input logic [2:0] sel);
		case (op)
			BSFU_BRANCH_FLAG_HIGH: return f[sel] == 1'b1;
			BSFU_BRANCH_FLAG_LOW: return f[sel] == 1'b0;
			BSFU_BRANCH_NO_CARRY: return f[`BSFU_FLG_C] == 1'b0;
			BSFU_BRANCH_UNS_GE: return f[`BSFU_FLG_C] == 1'b0;
			BSFU_BRANCH_SIGNED_GE: return (f[`BSFU_FLG_N] ^ f[`BSFU_FLG_V]) == 1'b0;
			BSFU_BRANCH_SIGNED_LT: return (f[`BSFU_FLG_N] ^ f[`BSFU_FLG_V]) == 1'b1;
			BSFU_BRANCH_HC_ON: return f[`BSFU_FLG_H] == 1'b1;
			BSFU_BRANCH_HC_OFF: return f[`BSFU_FLG_H] == 1'b0;
			BSFU_BRANCH_XFER_ON: return f[`BSFU_FLG_T] == 1'b1;
			BSFU_BRANCH_XFER_OFF: return f[`BSFU_FLG_T] == 1'b0;
			BSFU_BRANCH_OVF_ON: return f[`BSFU_FLG_V] == 1'b1;
			BSFU_BRANCH_OVF_OFF: return f[`BSFU_FLG_V] == 1'b0;
			BSFU_BRANCH_IRQ_ON: return f[`BSFU_FLG_I] == 1'b1;
			BSFU_BRANCH_IRQ_OFF: return f[`BSFU_FLG_I] == 1'b0;
			default: return 1'b0;
		endcase
	endfunction

	// condition of the skip instructions
	function automatic logic skip_cond(input bsfu_req_s r);
		case (r.op)
			BSFU_COMPARE_SKIP_EQ: return r.rd_val == r.rr_val;
			BSFU_SKIP_REG_BIT_LOW: return r.rd_val[r.bit_sel] == 1'b0;
			BSFU_SKIP_REG_BIT_HIGH: return r.rd_val[r.bit_sel] == 1'b1;
			BSFU_SKIP_IO_BIT_LOW: return r.io_bit == 1'b0;
			BSFU_SKIP_IO_BIT_HIGH: return r.io_bit == 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	assign take      = req_valid && req_ready;
	assign req_ready = (s_reg.fsm == BSFU_IDLE) && s_reg.ctrl_en;
	assign seq_pc    = req.pc + bsfu_pc_t'(1);
	assign br_pc     = req.pc + {{(`BSFU_PC_W-`BSFU_K_W){req.offset[`BSFU_K_W-1]}}, req.offset} + bsfu_pc_t'(1);
	assign rd_idx    = reg_index(paddr);
	assign wr_idx    = reg_index(paddr);

	// classify the request: condition, cycle count and destination
	always_comb begin
		cond = 1'b0;
		cyc  = `BSFU_CYC_SEQ;
		tgt  = seq_pc;
		case (req.op)
			BSFU_POINTER_JUMP: begin
				cond = 1'b1;
				cyc  = `BSFU_CYC_JUMP;
				tgt  = {{(`BSFU_PC_W-`BSFU_PTR_W){1'b0}}, req.zptr};
			end
			BSFU_POINTER_CALL: begin
				cond = 1'b1;
				cyc  = s_reg.ctrl_wide ? `BSFU_CYC_CALL22 : `BSFU_CYC_CALL16;
				tgt  = {{(`BSFU_PC_W-`BSFU_PTR_W){1'b0}}, req.zptr};
			end
			BSFU_COMPARE_SKIP_EQ, BSFU_SKIP_REG_BIT_LOW, BSFU_SKIP_REG_BIT_HIGH,
			BSFU_SKIP_IO_BIT_LOW, BSFU_SKIP_IO_BIT_HIGH: begin
				cond = skip_cond(req);
				if (cond) begin
					// longer skip only when the skipped instruction has two words
					cyc = req.next_two_word ? `BSFU_CYC_SKIP2 : `BSFU_CYC_SKIP1;
					tgt = req.pc + (req.next_two_word ? bsfu_pc_t'(3) : bsfu_pc_t'(2));
				end
			end
			BSFU_NOP: begin
				cond = 1'b0;
			end
			default: begin
				cond = branch_cond(req.op, req.flags, req.bit_sel);
				if (cond) begin
					cyc = `BSFU_CYC_BRANCH;
					tgt = br_pc;
				end
			end
		endcase
	end

	// next state of the whole unit
	always_comb begin
		s_next        = s_reg;
		fin           = 1'b0;
		fin_taken     = 1'b0;
		fin_pc        = s_reg.hold_pc;
		fin_cyc       = s_reg.hold_cyc;
		s_next.res.done   = 1'b0;
		s_next.push.valid = 1'b0;
		case (s_reg.fsm)
			BSFU_IDLE: begin
				if (take) begin
					s_next.last_op    = req.op;
					s_next.hold_taken = cond;
					s_next.hold_pc    = tgt;
					s_next.hold_cyc   = cyc;
					if (req.op == BSFU_POINTER_CALL) begin
						// return address goes out in the first cycle, pc follows later
						s_next.push.valid = 1'b1;
						s_next.push.addr  = seq_pc;
					end
					if (cyc == `BSFU_CYC_SEQ) begin
						fin       = 1'b1;
						fin_taken = cond;
						fin_pc    = tgt;
						fin_cyc   = cyc;
					end else begin
						s_next.fsm = BSFU_HOLD;
						s_next.cnt = cyc - 3'h1;
					end
				end
			end
			BSFU_HOLD: begin
				if (s_reg.cnt == 3'h1) begin
					fin        = 1'b1;
					fin_taken  = s_reg.hold_taken;
					s_next.fsm = BSFU_IDLE;
				end
				s_next.cnt = s_reg.cnt - 3'h1;
			end
			default: begin
				s_next.fsm = BSFU_IDLE;
			end
		endcase
		if (fin) begin
			s_next.res.done    = 1'b1;
			s_next.res.taken   = fin_taken;
			s_next.res.pc_next = fin_pc;
			s_next.res.cycles  = fin_cyc;
			s_next.last_pc     = fin_pc;
		end
		// redirect counter: a write clears it, a same-cycle redirect still counts
		if (psel && penable && pwrite && wr_idx == 3'h3) begin
			s_next.redir_cnt = (fin && fin_taken) ? 16'h0001 : 16'h0000;
		end else if (fin && fin_taken) begin
			s_next.redir_cnt = s_reg.redir_cnt + 16'h0001;
		end
		if (psel && penable && pwrite && wr_idx == 3'h0) begin
			s_next.ctrl_en   = pwdata[`BSFU_CTRL_EN];
			s_next.ctrl_wide = pwdata[`BSFU_CTRL_WIDE];
		end
		// read data and error are captured in the setup phase
		if (psel && !penable) begin
			s_next.pslverr = 1'b0;
			if (rd_idx == 3'h0) begin
				s_next.prdata = {30'h0, s_reg.ctrl_wide, s_reg.ctrl_en};
			end else if (rd_idx == 3'h1) begin
				s_next.prdata = {22'h0, s_reg.last_op, s_reg.res.cycles, s_reg.res.taken,
					s_reg.fsm == BSFU_HOLD};
			end else if (rd_idx == 3'h2) begin
				s_next.prdata = {{(32-`BSFU_PC_W){1'b0}}, s_reg.last_pc};
			end else if (rd_idx == 3'h3) begin
				s_next.prdata = {16'h0, s_reg.redir_cnt};
			end else begin
				s_next.prdata  = 32'h0;
				s_next.pslverr = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_reg           <= '0;
			s_reg.fsm       <= BSFU_IDLE;
			s_reg.last_op   <= BSFU_NOP;
			s_reg.ctrl_en   <= 1'((`BSFU_CTRL_RST >> `BSFU_CTRL_EN) & 2'h1);
			s_reg.ctrl_wide <= 1'((`BSFU_CTRL_RST >> `BSFU_CTRL_WIDE) & 2'h1);
		end else begin
			s_reg <= s_next;
		end
	end

	assign prdata  = s_reg.prdata;
	assign pslverr = s_reg.pslverr;
	assign pready  = psel && penable;
	assign res     = s_reg.res;
	assign push    = s_reg.push;

	default clocking bsfu_cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	a_jump_two_cycles: assert property (
		take && req.op == BSFU_POINTER_JUMP |-> ##1 !res.done ##1
			(res.done && res.taken && res.pc_next == {6'h00, $past(req.zptr, 2)}))
		else $error("pointer jump result wrong or late");

	a_call_wide_len: assert property (
		take && req.op == BSFU_POINTER_CALL && s_reg.ctrl_wide |-> ##1 !res.done [*3] ##1 res.done)
		else $error("wide pointer call not four cycles");

	a_call_narrow_len: assert property (
		take && req.op == BSFU_POINTER_CALL && !s_reg.ctrl_wide |-> ##1 !res.done [*2] ##1 res.done)
		else $error("narrow pointer call not three cycles");

	a_call_push_first: assert property (
		take && req.op == BSFU_POINTER_CALL |-> ##1 (push.valid && !res.done && push.addr == $past(req.pc) + 22'h1))
		else $error("return address not pushed before pc load");

	a_skip_equal_short: assert property (
		take && req.op == BSFU_COMPARE_SKIP_EQ && req.rd_val == req.rr_val && !req.next_two_word |->
			##1 !res.done ##1 (res.done && res.taken && res.pc_next == $past(req.pc, 2) + 22'h2))
		else $error("compare skip did not advance by two");

	a_skip_reg_fall: assert property (
		take && req.op == BSFU_SKIP_REG_BIT_LOW && req.rd_val[req.bit_sel] |->
			##1 (res.done && !res.taken && res.cycles == 3'h1))
		else $error("register bit skip taken on a set bit");

	a_skip_io_long: assert property (
		take && req.op == BSFU_SKIP_IO_BIT_HIGH && req.io_bit && req.next_two_word |->
			##1 !res.done [*2] ##1 (res.done && res.pc_next == $past(req.pc, 3) + 22'h3))
		else $error("io bit skip of a long instruction wrong");

	a_branch_flag_target: assert property (
		take && req.op == BSFU_BRANCH_FLAG_HIGH && req.flags[req.bit_sel] |->
			##2 (res.done && res.taken && res.pc_next ==
			$past(req.pc, 2) + {{15{$past(req.offset[6], 2)}}, $past(req.offset, 2)} + 22'h1))
		else $error("flag branch target wrong");

	a_carry_fall: assert property (
		take && req.op == BSFU_BRANCH_NO_CARRY && req.flags[`BSFU_FLG_C] |-> ##1 (res.done && !res.taken))
		else $error("branch on carry clear taken with carry set");

	a_signed_lt_taken: assert property (
		take && req.op == BSFU_BRANCH_SIGNED_LT && (req.flags[`BSFU_FLG_N] ^ req.flags[`BSFU_FLG_V]) |->
			##1 !res.done ##1 (res.done && res.taken))
		else $error("signed less-than branch not taken");

	a_busy_not_ready: assert property (
		s_reg.fsm == BSFU_HOLD |-> !req_ready)
		else $error("request accepted while busy");

	a_skip_reg_high: assert property (
		take && req.op == BSFU_SKIP_REG_BIT_HIGH && req.rd_val[req.bit_sel] && !req.next_two_word |->
			##1 !res.done ##1 (res.done && res.taken && res.pc_next == $past(req.pc, 2) + 22'h2))
		else $error("register bit skip missed on a set bit");

	a_skip_io_low: assert property (
		take && req.op == BSFU_SKIP_IO_BIT_LOW && !req.io_bit && !req.next_two_word |->
			##1 !res.done ##1 (res.done && res.taken && res.cycles == 3'h2))
		else $error("io bit skip missed on a clear bit");

	a_flag_low_taken: assert property (
		take && req.op == BSFU_BRANCH_FLAG_LOW && !req.flags[req.bit_sel] |->
			##1 !res.done ##1 (res.done && res.taken && res.cycles == 3'h2))
		else $error("branch on clear flag not taken");

	a_uns_ge_fall: assert property (
		take && req.op == BSFU_BRANCH_UNS_GE && req.flags[`BSFU_FLG_C] |->
			##1 (res.done && !res.taken && res.pc_next == $past(req.pc) + 22'h1))
		else $error("unsigned same-or-higher branch taken with carry set");

	a_signed_ge_fall: assert property (
		take && req.op == BSFU_BRANCH_SIGNED_GE && (req.flags[`BSFU_FLG_N] ^ req.flags[`BSFU_FLG_V]) |->
			##1 (res.done && !res.taken))
		else $error("signed greater-or-equal branch taken on less");

	a_hc_on_fall: assert property (
		take && req.op == BSFU_BRANCH_HC_ON && !req.flags[`BSFU_FLG_H] |->
			##1 (res.done && !res.taken))
		else $error("half-carry set branch taken with flag clear");

	a_hc_off_taken: assert property (
		take && req.op == BSFU_BRANCH_HC_OFF && !req.flags[`BSFU_FLG_H] |->
			##1 !res.done ##1 (res.done && res.taken))
		else $error("half-carry clear branch not taken");

	a_xfer_on_taken: assert property (
		take && req.op == BSFU_BRANCH_XFER_ON && req.flags[`BSFU_FLG_T] |->
			##1 !res.done ##1 (res.done && res.taken))
		else $error("transfer bit set branch not taken");

	a_xfer_off_fall: assert property (
		take && req.op == BSFU_BRANCH_XFER_OFF && req.flags[`BSFU_FLG_T] |->
			##1 (res.done && !res.taken))
		else $error("transfer bit clear branch taken with bit set");

	a_ovf_on_fall: assert property (
		take && req.op == BSFU_BRANCH_OVF_ON && !req.flags[`BSFU_FLG_V] |->
			##1 (res.done && !res.taken))
		else $error("overflow set branch taken with flag clear");

	a_ovf_off_taken: assert property (
		take && req.op == BSFU_BRANCH_OVF_OFF && !req.flags[`BSFU_FLG_V] |->
			##1 !res.done ##1 (res.done && res.taken))
		else $error("overflow clear branch not taken");

	a_irq_on_taken: assert property (
		take && req.op == BSFU_BRANCH_IRQ_ON && req.flags[`BSFU_FLG_I] |->
			##1 !res.done ##1 (res.done && res.taken))
		else $error("interrupt enabled branch not taken");

	a_irq_off_fall: assert property (
		take && req.op == BSFU_BRANCH_IRQ_OFF && req.flags[`BSFU_FLG_I] |->
			##1 (res.done && !res.taken))
		else $error("interrupt disabled branch taken with enable set");

	a_equal_miss: assert property (
		take && req.op == BSFU_COMPARE_SKIP_EQ && req.rd_val != req.rr_val |->
			##1 (res.done && !res.taken && res.cycles == 3'h1))
		else $error("compare skip taken on unequal registers");

	a_nop_single: assert property (
		take && req.op == BSFU_NOP |->
			##1 (res.done && !res.taken && res.cycles == 3'h1 && res.pc_next == $past(req.pc) + 22'h1))
		else $error("no-operation not finished in one cycle");

	a_fall_one_cycle: assert property (
		res.done && !res.taken |->
			res.cycles == 3'h1)
		else $error("untaken result reports more than one cycle");

	a_call_narrow_pc: assert property (
		take && req.op == BSFU_POINTER_CALL && !s_reg.ctrl_wide |->
			##3 (res.done && res.taken && res.cycles == 3'h3 && res.pc_next == {6'h00, $past(req.zptr, 3)}))
		else $error("narrow pointer call result wrong");

	a_hold_quiet: assert property (
		s_reg.fsm == BSFU_HOLD && s_reg.cnt != 3'h1 |->
			##1 !res.done)
		else $error("result finished before its cycle count");

endmodule

// ### tb/bsfu_fetch_model.sv
// fetch and decode side: issues one operation with its operands and flags
// assumes bsfu_pkg is compiled first; holds each request until taken
`timescale 1ns/1ps
module bsfu_fetch_model
	import bsfu_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       start,
	input  bsfu_req_s       cmd,
	input  wire logic [1:0] lag,
	input  wire logic       req_ready,
	output bsfu_req_s       req,
	output logic            req_valid
);
	logic [1:0] wait_reg;
	logic       pend_reg;

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			req <= '0;
			req_valid <= 1'b0;
			pend_reg <= 1'b0;
			wait_reg <= 2'h0;
		end else if (start) begin
			req <= cmd;
			pend_reg <= 1'b1;
			wait_reg <= lag;
		end else if (req_valid && req_ready) begin
			req_valid <= 1'b0;
			// released operands no longer show the old value
			req <= ~req;
		end else if (pend_reg) begin
			if (wait_reg == 2'h0) begin
				req_valid <= 1'b1;
				pend_reg <= 1'b0;
			end else begin
				wait_reg <= wait_reg - 2'h1;
			end
		end
	end
endmodule

// ### tb/bsfu_flow_unit_bench.sv
// self-checking bench of the branch and skip flow unit
// assumes the fetch model drives the request port and the bench is apb master
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module bsfu_flow_unit_bench;
	import bsfu_pkg::*;
	logic        clk, nrst, psel, penable, pwrite, pready, pslverr;
	logic        req_valid, req_ready, start, er, wide;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0]  lag;
	logic [2:0]  lat, lat_done;
	bsfu_req_s   req, cmd, r;
	bsfu_res_s   res, ex;
	bsfu_push_s  push;
	bsfu_pc_t    push_addr;
	bsfu_op_e    lop;
	int          fails, checks, cyc, seed, taken_cnt, push_cnt;

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	bsfu_flow_unit dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.req(req), .req_valid(req_valid), .req_ready(req_ready), .res(res), .push(push));
	bsfu_fetch_model fetch (.clk(clk), .nrst(nrst), .start(start), .cmd(cmd), .lag(lag),
		.req_ready(req_ready), .req(req), .req_valid(req_valid));

	// cycles from take to done, push pulses, hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		lat <= (req_valid && req_ready) ? 3'h0 : lat + 3'h1;
		if (res.done) lat_done <= lat + 3'h1;
		if (push.valid) begin
			push_cnt <= push_cnt + 1;
			push_addr <= push.addr;
		end
		if (cyc == 6000) begin
			fails++;
			wrap_up;
		end
	end

	function automatic bsfu_res_s expect_res(bsfu_req_s q, logic w);
		bsfu_res_s e;
		logic c;
		logic [7:0] f;
		f = q.flags;
		e = '0;
		e.done = 1'b1;
		c = 1'b0;
		case (q.op)
			BSFU_COMPARE_SKIP_EQ: c = q.rd_val == q.rr_val;
			BSFU_SKIP_REG_BIT_LOW: c = !q.rr_val[q.bit_sel];
			BSFU_SKIP_REG_BIT_HIGH: c = q.rr_val[q.bit_sel];
			BSFU_SKIP_IO_BIT_LOW: c = !q.io_bit;
			BSFU_SKIP_IO_BIT_HIGH: c = q.io_bit;
			BSFU_BRANCH_FLAG_HIGH: c = f[q.bit_sel];
			BSFU_BRANCH_FLAG_LOW: c = !f[q.bit_sel];
			BSFU_BRANCH_NO_CARRY: c = !f[0];
			BSFU_BRANCH_UNS_GE: c = !f[0];
			BSFU_BRANCH_SIGNED_GE: c = !(f[2] ^ f[3]);
			BSFU_BRANCH_SIGNED_LT: c = f[2] ^ f[3];
			BSFU_BRANCH_HC_ON: c = f[5];
			BSFU_BRANCH_HC_OFF: c = !f[5];
			BSFU_BRANCH_XFER_ON: c = f[6];
			BSFU_BRANCH_XFER_OFF: c = !f[6];
			BSFU_BRANCH_OVF_ON: c = f[3];
			BSFU_BRANCH_OVF_OFF: c = !f[3];
			BSFU_BRANCH_IRQ_ON: c = f[7];
			BSFU_BRANCH_IRQ_OFF: c = !f[7];
			default: c = 1'b0;
		endcase
		if (q.op == BSFU_POINTER_JUMP || q.op == BSFU_POINTER_CALL) begin
			e.taken = 1'b1;
			e.pc_next = {6'h0, q.zptr};
			e.cycles = (q.op == BSFU_POINTER_JUMP) ? 3'h2 : (w ? 3'h4 : 3'h3);
		end else if (!c) begin
			e.pc_next = q.pc + 22'h1;
			e.cycles = 3'h1;
		end else if (q.op >= BSFU_COMPARE_SKIP_EQ && q.op <= BSFU_SKIP_IO_BIT_HIGH) begin
			e.taken = 1'b1;
			e.cycles = q.next_two_word ? 3'h3 : 3'h2;
			e.pc_next = q.pc + 22'(e.cycles);
		end else begin
			e.taken = 1'b1;
			e.cycles = 3'h2;
			e.pc_next = q.pc + {{15{q.offset[6]}}, q.offset} + 22'h1;
		end
		return e;
	endfunction

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic run_op(input bsfu_req_s q);
		int n;
		int p0;
		if (q.op == BSFU_SKIP_REG_BIT_LOW || q.op == BSFU_SKIP_REG_BIT_HIGH) q.rd_val = q.rr_val;
		ex = expect_res(q, wide);
		lop = q.op;
		p0 = push_cnt;
		cmd <= q;
		start <= 1'b1;
		lag <= 2'($random(seed));
		@(posedge clk);
		start <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (res.done !== 1'b1 && n < 40);
		#1;
		`CHK("taken", ex.taken, res.taken)
		`CHK("pc_next", ex.pc_next, res.pc_next)
		`CHK("cycles", ex.cycles, res.cycles)
		`CHK("latency", ex.cycles, lat_done)
		if (ex.taken) taken_cnt++;
		if (q.op == BSFU_POINTER_CALL) begin
			`CHK("push addr", q.pc + 22'h1, push_addr)
			`CHK("push count", p0 + 1, push_cnt)
		end
		@(posedge clk);
	endtask

	function automatic bsfu_req_s rnd_req(input int op);
		bsfu_req_s   q;
		logic [95:0] raw;
		raw = {$random(seed), $random(seed), $random(seed)};
		q = raw[$bits(bsfu_req_s)-1:0];
		q.op = bsfu_op_e'(op[4:0]);
		return q;
	endfunction

	task wrap_up;
		$display("counts: checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	initial begin
		{nrst, psel, penable, pwrite, start, wide, lag} = 8'h04;
		{paddr, pwdata, cmd} = '0;
		{fails, checks, cyc, taken_cnt, push_cnt} = '0;
		seed = 92;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		apb(1'b0, 12'h000, 32'h0);
		`CHK("ctrl reset", 32'h3, rd)
		apb(1'b0, 12'h010, 32'h0);
		`CHK("unmapped err", 1'b1, er)
		`CHK("unmapped data", 32'h0, rd)
		apb(1'b1, 12'h00c, 32'h0);
		$display("registers test done");
		for (int op = 0; op < 22; op++) begin
			for (int k = 0; k < 2; k++) begin
				r = rnd_req(op);
				{r.flags, r.io_bit, r.next_two_word} = {10{k[0]}};
				r.rr_val = k[0] ? r.rd_val : ~r.rd_val;
				r.offset = k[0] ? 7'h40 : 7'h3f;
				if (k[0]) r.pc = 22'h3fffff;
				run_op(r);
			end
		end
		$display("corner test done");
		apb(1'b1, 12'h000, 32'h1);
		wide = 1'b0;
		run_op(rnd_req(2));
		repeat (80) run_op(rnd_req($unsigned($random(seed)) % 22));
		$display("random test done");
		apb(1'b0, 12'h00c, 32'h0);
		`CHK("redirect count", taken_cnt[15:0], rd[15:0])
		apb(1'b0, 12'h008, 32'h0);
		`CHK("last pc", {10'h0, ex.pc_next}, rd)
		apb(1'b0, 12'h004, 32'h0);
		`CHK("status", {lop, ex.cycles, ex.taken, 1'b0}, rd[9:0])
		$display("status test done");
		wrap_up;
	end
endmodule
